// file: common/dbc_pkg.sv
// constants and types shared by the debounced edge counter
// What this block does
// - mode 0 counts falling, restarting timeout, debounce all
// - mode 1 counts rising, restarting timeout, debounce all
// - mode 2 counts both edges, restarting timeout
// - modes 3/4 falling/rising with fixed timeout
// - mode 5 low hold, then any edge counts
// - mode 6 high hold, then any edge counts
// - edge during restarting timeout reloads full value
// - each counted edge adds exactly one
// - edges ignored until debounce timeout elapses
// - timeout in microseconds, zero to one million
// - mode field selects one of seven behaviours
// - count read returns count unchanged
// - clear-on-read returns count, then clears it
// - clear lands a short window after capture
// - stream reads give low half, capture upper
// - each accepted edge of either polarity is serviced
// - one edge service lasts 14 us, shared by all channels
// - edge sets pending, service completion clears it
// - stream servicing preempts edge servicing
// - edge while pending is lost, not queued
package dbc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
  // longest service time: rounded down
  localparam int SERVICE_TIME_US = 14;
  localparam int SERVICE_CYCLES =
    SERVICE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  // least capture-to-clear gap: rounded up
  localparam int CLEAR_WINDOW_US = 10;
  localparam int CLEAR_CYCLES =
    (CLEAR_WINDOW_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int TIMEOUT_W = 20;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_MAX_US = 20'hF4240;
  localparam int MODE_W = 3;
  localparam int FSEL_W = 8;
  localparam logic [FSEL_W-1:0] FEATURE_DEBOUNCE = 8'h09;
  localparam int STREAM_W = 16;

  localparam logic [MODE_W-1:0] MODE_FALL_RESTART = 3'h0;
  localparam logic [MODE_W-1:0] MODE_RISE_RESTART = 3'h1;
  localparam logic [MODE_W-1:0] MODE_BOTH_RESTART = 3'h2;
  localparam logic [MODE_W-1:0] MODE_FALL_FIXED = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RISE_FIXED = 3'h4;
  localparam logic [MODE_W-1:0] MODE_FALL_HOLD = 3'h5;
  localparam logic [MODE_W-1:0] MODE_RISE_HOLD = 3'h6;

  // ----------------------------------------------------------------
  // register map: addr = {channel, register}
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int CH_FIELD_W = 4;
  localparam int REG_FIELD_W = 4;
  localparam logic [CH_FIELD_W-1:0] GLOBAL_CH = 4'hF;
  localparam logic [REG_FIELD_W-1:0] REG_ENABLE = 4'h0;
  localparam logic [REG_FIELD_W-1:0] REG_SELECT = 4'h1;
  localparam logic [REG_FIELD_W-1:0] REG_TIMEOUT = 4'h2;
  localparam logic [REG_FIELD_W-1:0] REG_MODE = 4'h3;
  localparam logic [REG_FIELD_W-1:0] REG_COUNT = 4'h4;
  localparam logic [REG_FIELD_W-1:0] REG_COUNT_COR = 4'h5;
  localparam logic [REG_FIELD_W-1:0] REG_STATUS = 4'h6;
  localparam logic [REG_FIELD_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [REG_FIELD_W-1:0] REG_CAPTURE = 4'h1;

  typedef enum logic [1:0] {
    DBC_IDLE = 2'h0,
    DBC_TIMING = 2'h1,
    DBC_ARMED = 2'h3
  } dbc_state_type;

endpackage

// file: rtl/dbc_us_tick.sv
// one-cycle pulse every microsecond
`timescale 1ns/10ps
`default_nettype none
module dbc_us_tick #(
  parameter int CYCLES = dbc_pkg::CYCLES_PER_US
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // tick out
  output logic tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt;

  assign tick = (cnt == LAST);

  always_ff @(posedge clk) begin
    if (reset || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/dbc_channel.sv
// per-channel debounce state machine and pending flag
`timescale 1ns/10ps
`default_nettype none
module dbc_channel (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic active,
  input wire logic [dbc_pkg::MODE_W-1:0] mode,
  input wire logic [dbc_pkg::TIMEOUT_W-1:0] timeout,
  input wire logic us_tick,
  // line and service
  input wire logic pin,
  input wire logic svc_done,
  output logic pending,
  output logic pend_count,
  output logic overrun,
  output dbc_pkg::dbc_state_type state
);
  logic prev_pin;
  logic [dbc_pkg::TIMEOUT_W-1:0] tmr;
  dbc_pkg::dbc_state_type next_state;
  logic next_hit;
  logic load;

  wire edge_seen = active && (pin != prev_pin);
  wire rising = edge_seen && pin;
  wire falling = edge_seen && !pin;
  // set wins over the completing service
  wire accept = edge_seen && (!pending || svc_done);
  wire expired = (state == dbc_pkg::DBC_TIMING) && (tmr == '0);
  wire hold_start = (mode == dbc_pkg::MODE_FALL_HOLD) ? falling : rising;
  wire hold_cancel = (mode == dbc_pkg::MODE_FALL_HOLD) ? rising : falling;
  wire fall_app = (mode == dbc_pkg::MODE_FALL_RESTART) ||
    (mode == dbc_pkg::MODE_FALL_FIXED);
  wire rise_app = (mode == dbc_pkg::MODE_RISE_RESTART) ||
    (mode == dbc_pkg::MODE_RISE_FIXED);
  wire applicable = (fall_app && falling) || (rise_app && rising) ||
    ((mode == dbc_pkg::MODE_BOTH_RESTART) && edge_seen);

  assign overrun = edge_seen && pending && !svc_done;

  always_comb begin
    next_state = state;
    next_hit = 1'b0;
    load = 1'b0;
    case (mode)
      dbc_pkg::MODE_FALL_RESTART,
      dbc_pkg::MODE_RISE_RESTART,
      dbc_pkg::MODE_BOTH_RESTART: begin
        if (accept && state == dbc_pkg::DBC_TIMING) begin
          load = 1'b1;
        end else if (accept) begin
          // release bounce also starts the timeout
          next_hit = applicable;
          load = 1'b1;
          next_state = dbc_pkg::DBC_TIMING;
        end else if (expired) begin
          next_state = dbc_pkg::DBC_IDLE;
        end
      end
      dbc_pkg::MODE_FALL_FIXED,
      dbc_pkg::MODE_RISE_FIXED: begin
        if (accept && applicable && state != dbc_pkg::DBC_TIMING) begin
          next_hit = 1'b1;
          load = 1'b1;
          next_state = dbc_pkg::DBC_TIMING;
        end else if (expired) begin
          next_state = dbc_pkg::DBC_IDLE;
        end
      end
      dbc_pkg::MODE_FALL_HOLD,
      dbc_pkg::MODE_RISE_HOLD: begin
        case (state)
          dbc_pkg::DBC_IDLE: begin
            if (accept && hold_start) begin
              load = 1'b1;
              next_state = dbc_pkg::DBC_TIMING;
            end
          end
          dbc_pkg::DBC_TIMING: begin
            if (accept && hold_cancel) begin
              next_state = dbc_pkg::DBC_IDLE;
            end else if (accept) begin
              load = 1'b1;
            end else if (expired) begin
              next_state = dbc_pkg::DBC_ARMED;
            end
          end
          dbc_pkg::DBC_ARMED: begin
            if (accept) begin
              next_hit = 1'b1;
              next_state = dbc_pkg::DBC_IDLE;
            end
          end
          default: next_state = dbc_pkg::DBC_IDLE;
        endcase
      end
      default: next_state = dbc_pkg::DBC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_pin <= 1'b0;
    end else begin
      prev_pin <= pin;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !active) begin
      state <= dbc_pkg::DBC_IDLE;
      tmr <= '0;
      pending <= 1'b0;
      pend_count <= 1'b0;
    end else begin
      state <= next_state;
      if (load) begin
        tmr <= timeout;
      end else if (us_tick && tmr != '0) begin
        tmr <= tmr - 1'b1;
      end
      if (accept) begin
        pending <= 1'b1;
        pend_count <= next_hit;
      end else if (svc_done) begin
        pending <= 1'b0;
        pend_count <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/dbc_edge_counter.sv
// debounced edge counter: registers, shared edge service, counts
`timescale 1ns/10ps
`default_nettype none
module dbc_edge_counter #(
  parameter int NUM_CH = 6,
  parameter int COUNT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [dbc_pkg::ADDR_W-1:0] addr,
  input wire logic [dbc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [dbc_pkg::DATA_W-1:0] rdata,
  // input lines
  input wire logic [NUM_CH-1:0] pins,
  // stream engine holds edge service while high
  input wire logic stream_req,
  // service status
  output logic service_busy
);
  localparam int CH_IDX_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int SVC_W = $clog2(dbc_pkg::SERVICE_CYCLES);
  localparam logic [SVC_W-1:0] SVC_LOAD =
    SVC_W'(dbc_pkg::SERVICE_CYCLES - 1);
  localparam int CLR_W = $clog2(dbc_pkg::CLEAR_CYCLES);
  localparam logic [CLR_W-1:0] CLR_LOAD =
    CLR_W'(dbc_pkg::CLEAR_CYCLES - 1);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire [dbc_pkg::CH_FIELD_W-1:0] ch_sel =
    addr[dbc_pkg::ADDR_W-1:dbc_pkg::REG_FIELD_W];
  wire [dbc_pkg::REG_FIELD_W-1:0] reg_sel =
    addr[dbc_pkg::REG_FIELD_W-1:0];
  wire is_global = (ch_sel == dbc_pkg::GLOBAL_CH);
  wire ch_ok = (ch_sel < dbc_pkg::CH_FIELD_W'(NUM_CH));
  wire [CH_IDX_W-1:0] ch_idx = ch_sel[CH_IDX_W-1:0];
  wire count_read = rd && ch_ok && ((reg_sel == dbc_pkg::REG_COUNT) ||
    (reg_sel == dbc_pkg::REG_COUNT_COR));
  wire ctrl_write = wr && is_global && (reg_sel == dbc_pkg::REG_CONTROL);
  wire timeout_big = (wdata > dbc_pkg::DATA_W'(dbc_pkg::TIMEOUT_MAX_US));
  wire mode_ok = (wdata <= dbc_pkg::DATA_W'(dbc_pkg::MODE_RISE_HOLD));

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic en [NUM_CH];
  logic [dbc_pkg::FSEL_W-1:0] fsel [NUM_CH];
  logic [dbc_pkg::TIMEOUT_W-1:0] tmo [NUM_CH];
  logic [dbc_pkg::MODE_W-1:0] mode [NUM_CH];
  logic [COUNT_W-1:0] count [NUM_CH];
  logic ovr [NUM_CH];
  logic clr_run [NUM_CH];
  logic [CLR_W-1:0] clr_cnt [NUM_CH];
  dbc_pkg::dbc_state_type ch_state [NUM_CH];
  logic [NUM_CH-1:0] pend_vec;
  logic [NUM_CH-1:0] pend_cnt_vec;
  logic [NUM_CH-1:0] ovr_pulse;
  logic stream_mode;
  logic [dbc_pkg::STREAM_W-1:0] capture;
  logic us_tick;

  // ----------------------------------------------------------------
  // shared edge service engine
  // ----------------------------------------------------------------
  logic [CH_IDX_W-1:0] cur_ch;
  logic [SVC_W-1:0] svc_cnt;
  logic [CH_IDX_W-1:0] next_pick;
  logic any_pend;

  // fixed priority: lowest channel first, one at a time
  always_comb begin
    next_pick = '0;
    any_pend = 1'b0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (pend_vec[k]) begin
        next_pick = CH_IDX_W'(k);
        any_pend = 1'b1;
      end
    end
  end

  wire svc_fin = service_busy && (svc_cnt == '0) && !stream_req;

  always_ff @(posedge clk) begin
    if (reset) begin
      service_busy <= 1'b0;
      cur_ch <= '0;
      svc_cnt <= '0;
    end else if (!service_busy) begin
      if (any_pend) begin
        service_busy <= 1'b1;
        cur_ch <= next_pick;
        svc_cnt <= SVC_LOAD;
      end
    end else if (stream_req) begin
      // stream work runs first; edge service just waits
      svc_cnt <= svc_cnt;
    end else if (svc_cnt == '0) begin
      service_busy <= 1'b0;
    end else begin
      svc_cnt <= svc_cnt - 1'b1;
    end
  end

  dbc_us_tick #(
    .CYCLES(dbc_pkg::CYCLES_PER_US)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .tick(us_tick)
  );

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      wire sel = ch_ok && (ch_idx == CH_IDX_W'(i));
      wire cfg_wr = wr && sel && !en[i];
      wire cor_read = rd && sel && (reg_sel == dbc_pkg::REG_COUNT_COR);
      wire stat_read = rd && sel && (reg_sel == dbc_pkg::REG_STATUS);
      wire done = svc_fin && (cur_ch == CH_IDX_W'(i));
      wire active = en[i] && (fsel[i] == dbc_pkg::FEATURE_DEBOUNCE);

      dbc_channel u_ch (
        .clk(clk),
        .reset(reset),
        .active(active),
        .mode(mode[i]),
        .timeout(tmo[i]),
        .us_tick(us_tick),
        .pin(pins[i]),
        .svc_done(done),
        .pending(pend_vec[i]),
        .pend_count(pend_cnt_vec[i]),
        .overrun(ovr_pulse[i]),
        .state(ch_state[i])
      );

      always_ff @(posedge clk) begin
        if (reset) begin
          en[i] <= 1'b0;
          fsel[i] <= '0;
          tmo[i] <= '0;
          mode[i] <= dbc_pkg::MODE_FALL_RESTART;
        end else begin
          if (wr && sel && reg_sel == dbc_pkg::REG_ENABLE) begin
            en[i] <= wdata[0];
          end
          // settings only change while the channel is off
          if (cfg_wr && reg_sel == dbc_pkg::REG_SELECT) begin
            fsel[i] <= wdata[dbc_pkg::FSEL_W-1:0];
          end
          if (cfg_wr && reg_sel == dbc_pkg::REG_TIMEOUT) begin
            tmo[i] <= timeout_big ? dbc_pkg::TIMEOUT_MAX_US :
              wdata[dbc_pkg::TIMEOUT_W-1:0];
          end
          if (cfg_wr && reg_sel == dbc_pkg::REG_MODE && mode_ok) begin
            mode[i] <= wdata[dbc_pkg::MODE_W-1:0];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          ovr[i] <= 1'b0;
        end else if (ovr_pulse[i]) begin
          ovr[i] <= 1'b1;
        end else if (stat_read) begin
          ovr[i] <= 1'b0;
        end
      end

      // clear lands after the gap; counts in between are lost
      always_ff @(posedge clk) begin
        if (reset) begin
          clr_run[i] <= 1'b0;
          clr_cnt[i] <= '0;
        end else if (cor_read) begin
          clr_run[i] <= 1'b1;
          clr_cnt[i] <= CLR_LOAD;
        end else if (clr_run[i] && clr_cnt[i] == '0) begin
          clr_run[i] <= 1'b0;
        end else if (clr_run[i]) begin
          clr_cnt[i] <= clr_cnt[i] - 1'b1;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          count[i] <= '0;
        end else if (clr_run[i] && clr_cnt[i] == '0) begin
          count[i] <= '0;
        end else if (done && pend_cnt_vec[i]) begin
          count[i] <= count[i] + 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [dbc_pkg::DATA_W-1:0] read_value;
  logic [dbc_pkg::DATA_W-1:0] count_word;

  always_comb begin
    count_word = ch_ok ? dbc_pkg::DATA_W'(count[ch_idx]) : '0;
    read_value = '0;
    if (is_global) begin
      case (reg_sel)
        dbc_pkg::REG_CONTROL: read_value = dbc_pkg::DATA_W'(stream_mode);
        dbc_pkg::REG_CAPTURE: read_value = dbc_pkg::DATA_W'(capture);
        default: read_value = '0;
      endcase
    end else if (ch_ok) begin
      case (reg_sel)
        dbc_pkg::REG_ENABLE: read_value = dbc_pkg::DATA_W'(en[ch_idx]);
        dbc_pkg::REG_SELECT: read_value = dbc_pkg::DATA_W'(fsel[ch_idx]);
        dbc_pkg::REG_TIMEOUT: read_value = dbc_pkg::DATA_W'(tmo[ch_idx]);
        dbc_pkg::REG_MODE: read_value = dbc_pkg::DATA_W'(mode[ch_idx]);
        dbc_pkg::REG_COUNT,
        dbc_pkg::REG_COUNT_COR: begin
          // stream reads carry the low half only
          read_value = stream_mode ?
            dbc_pkg::DATA_W'(count_word[dbc_pkg::STREAM_W-1:0]) :
            count_word;
        end
        dbc_pkg::REG_STATUS: read_value = dbc_pkg::DATA_W'(
          {ch_state[ch_idx], ovr[ch_idx], pend_vec[ch_idx]});
        default: read_value = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
      stream_mode <= 1'b0;
      capture <= '0;
    end else begin
      rdata <= rd ? read_value : '0;
      if (ctrl_write) begin
        stream_mode <= wdata[0];
      end
      if (count_read && stream_mode) begin
        capture <= count_word[dbc_pkg::DATA_W-1:dbc_pkg::STREAM_W];
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/dbc_pulse_src.sv
// behavioural pulse source on the counter's input lines
`timescale 1ns/10ps
`default_nettype none
module dbc_pulse_src #(
  parameter int NUM_CH = 6
) (
  // clock
  input wire logic clk,
  // lines
  output logic [NUM_CH-1:0] pins
);
  initial pins = '0;
  // holds under one service time lose the next edge only if that channel is still pending
  task automatic step(input int ch, input logic lvl, input int hold);
    @(posedge clk);
    pins[ch] <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/dbc_edge_counter_sva.sv
// port checker for the debounced edge counter
`timescale 1ns/10ps
`default_nettype none
module dbc_edge_counter_sva #(
  parameter int NUM_CH = 6,
  parameter int COUNT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [dbc_pkg::ADDR_W-1:0] addr,
  input wire logic [dbc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [dbc_pkg::DATA_W-1:0] rdata,
  // lines and service
  input wire logic [NUM_CH-1:0] pins,
  input wire logic stream_req,
  input wire logic service_busy
);
  // one service takes the full count of quiet busy cycles; the check accepts one fewer
  localparam int SVC_MIN = dbc_pkg::SERVICE_CYCLES - 1;
  logic [NUM_CH-1:0] en;
  logic [2:0] mode_sh [NUM_CH];
  logic [19:0] tmo_sh [NUM_CH];
  logic [7:0] sel_sh [NUM_CH];
  logic strm;
  logic last_rd;
  logic [7:0] last_addr;
  logic [15:0] bcnt;
  wire logic [3:0] ch = addr[7:4];
  wire logic [3:0] rg = addr[3:0];
  wire logic [3:0] lch = last_addr[7:4];
  wire logic [3:0] lrg = last_addr[3:0];
  wire logic cfg_ok = wr && ch < NUM_CH && !en[ch];

  // shadow of what the registers must hold
  always_ff @(posedge clk) begin
    if (reset) begin
      en <= '0;
      strm <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        mode_sh[i] <= 3'h0;
        tmo_sh[i] <= 20'h00000;
        sel_sh[i] <= 8'h00;
      end
    end else begin
      if (wr && ch < NUM_CH && rg == dbc_pkg::REG_ENABLE)
        en[ch] <= wdata[0];
      if (cfg_ok && rg == dbc_pkg::REG_SELECT)
        sel_sh[ch] <= wdata[7:0];
      if (cfg_ok && rg == dbc_pkg::REG_MODE && wdata < 32'h7)
        mode_sh[ch] <= wdata[2:0];
      if (cfg_ok && rg == dbc_pkg::REG_TIMEOUT)
        tmo_sh[ch] <= (wdata > 32'h000F4240) ?
          dbc_pkg::TIMEOUT_MAX_US : wdata[19:0];
      if (wr && ch == dbc_pkg::GLOBAL_CH && rg == dbc_pkg::REG_CONTROL)
        strm <= wdata[0];
    end
  end

  // busy cycles with the stream engine quiet
  always_ff @(posedge clk) begin
    last_rd <= rd && !reset;
    last_addr <= addr;
    if (reset || !service_busy) bcnt <= 16'h0000;
    else if (!stream_req) bcnt <= bcnt + 16'h0001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_rd(logic [3:0] r);
    last_rd && lrg == r && lch < NUM_CH;
  endsequence
  sequence s_frozen;
    stream_req ##1 service_busy && stream_req ##1 stream_req;
  endsequence

  chk_mode_keep: assert property (
    s_rd(dbc_pkg::REG_MODE) |-> rdata == {29'h0, mode_sh[lch]})
    else $error("mode readback wrong");
  chk_timeout_clamp: assert property (
    s_rd(dbc_pkg::REG_TIMEOUT) |-> rdata == {12'h000, tmo_sh[lch]})
    else $error("timeout readback wrong");
  chk_select_keep: assert property (
    s_rd(dbc_pkg::REG_SELECT) |-> rdata == {24'h0, sel_sh[lch]})
    else $error("select readback wrong");
  chk_enable_read: assert property (
    s_rd(dbc_pkg::REG_ENABLE) |-> rdata == {31'h0, en[lch]})
    else $error("enable readback wrong");
  chk_stream_low: assert property (
    s_rd(dbc_pkg::REG_COUNT) ##0 strm |-> rdata[31:16] == 16'h0000)
    else $error("stream read upper half not zero");
  chk_stream_hold: assert property (
    s_frozen |=> service_busy)
    else $error("service ended while stream held");
  chk_service_len: assert property (
    $fell(service_busy) |-> bcnt >= SVC_MIN)
    else $error("service shorter than its time");
  chk_service_min: assert property (
    $rose(service_busy) |-> service_busy[*8])
    else $error("service dropped early");
endmodule

bind dbc_edge_counter dbc_edge_counter_sva #(
  .NUM_CH(NUM_CH),
  .COUNT_W(COUNT_W)
) dbc_edge_counter_sva_i (
  .clk(clk),
  .reset(reset),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .pins(pins),
  .stream_req(stream_req),
  .service_busy(service_busy)
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking testbench for the debounced edge counter
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, reset, wr, rd, stream_req, service_busy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, b0, b1;
  logic [5:0] pins;
  int fails = 0;
  int n_tests = 0;
  // count gain per mode for the fixed edge pattern
  int gain [7] = '{1, 2, 3, 2, 2, 2, 0};

  dbc_edge_counter #(.NUM_CH(6), .COUNT_W(32)) dbc_edge_counter_i (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pins(pins), .stream_req(stream_req),
    .service_busy(service_busy));
  dbc_pulse_src #(.NUM_CH(6)) dbc_pulse_src_i (.clk(clk), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------
  // bus access and comparison
  // ------------------------------------------------
  task automatic wr_reg(input logic [3:0] c, r, input logic [31:0] d);
    @(posedge clk);
    addr <= {c, r};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] c, r, output logic [31:0] d);
    @(posedge clk);
    addr <= {c, r};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [3:0] c, r, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(c, r, d);
    check(d, e);
  endtask
  task automatic cfg(input logic [3:0] c, input logic [31:0] m, t);
    wr_reg(c, dbc_pkg::REG_ENABLE, 32'h0);
    wr_reg(c, dbc_pkg::REG_SELECT, {24'h0, dbc_pkg::FEATURE_DEBOUNCE});
    wr_reg(c, dbc_pkg::REG_TIMEOUT, t);
    wr_reg(c, dbc_pkg::REG_MODE, m);
    wr_reg(c, dbc_pkg::REG_ENABLE, 32'h1);
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    stream_req = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    chk_reg(4'h0, dbc_pkg::REG_MODE, 32'h0);
    wr_reg(4'h0, dbc_pkg::REG_TIMEOUT, 32'h001E8480);
    chk_reg(4'h0, dbc_pkg::REG_TIMEOUT, 32'h000F4240);
    wr_reg(4'h0, dbc_pkg::REG_MODE, 32'h7);
    chk_reg(4'h0, dbc_pkg::REG_MODE, 32'h0);
    chk_reg(4'h0, 4'hE, 32'h0);
    // ------------------------------------------------
    // every mode on one pattern, timeout 20 us
    // ------------------------------------------------
    for (int m = 0; m < 7; m++) begin
      wr_reg(4'h0, dbc_pkg::REG_ENABLE, 32'h0);
      dbc_pulse_src_i.step(0, 1'b1, 10);
      cfg(4'h0, m, 32'd20);
      wr_reg(4'h0, dbc_pkg::REG_MODE, 32'h6);
      chk_reg(4'h0, dbc_pkg::REG_MODE, m);
      rd_reg(4'h0, dbc_pkg::REG_COUNT, b0);
      dbc_pulse_src_i.step(0, 1'b0, 700);
      dbc_pulse_src_i.step(0, 1'b1, 400);
      dbc_pulse_src_i.step(0, 1'b0, 700);
      dbc_pulse_src_i.step(0, 1'b1, 700);
      rd_reg(4'h0, dbc_pkg::REG_COUNT, v);
      check(v - b0, gain[m]);
    end
    // ------------------------------------------------
    // lost edge while pending, shared service, stream
    // ------------------------------------------------
    cfg(4'h0, 32'h2, 32'h0);
    rd_reg(4'h0, dbc_pkg::REG_COUNT, b0);
    dbc_pulse_src_i.step(0, 1'b0, 100);
    rd_reg(4'h0, dbc_pkg::REG_STATUS, v);
    check(v & 32'h3, 32'h1);
    dbc_pulse_src_i.step(0, 1'b1, 400);
    rd_reg(4'h0, dbc_pkg::REG_STATUS, v);
    check(v & 32'h3, 32'h2);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, b0 + 32'h1);
    cfg(4'h1, 32'h2, 32'h0);
    rd_reg(4'h1, dbc_pkg::REG_COUNT, b1);
    dbc_pulse_src_i.step(0, 1'b0, 0);
    dbc_pulse_src_i.step(1, 1'b1, 300);
    chk_reg(4'h1, dbc_pkg::REG_COUNT, b1);
    repeat (500) @(posedge clk);
    chk_reg(4'h1, dbc_pkg::REG_COUNT, b1 + 32'h1);
    dbc_pulse_src_i.step(0, 1'b1, 20);
    stream_req <= 1'b1;
    repeat (600) @(posedge clk);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, b0 + 32'h2);
    stream_req <= 1'b0;
    repeat (400) @(posedge clk);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, b0 + 32'h3);
    // ------------------------------------------------
    // stream reads and clear on read
    // ------------------------------------------------
    wr_reg(dbc_pkg::GLOBAL_CH, dbc_pkg::REG_CONTROL, 32'h1);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, b0 + 32'h3);
    chk_reg(dbc_pkg::GLOBAL_CH, dbc_pkg::REG_CAPTURE, 32'h0);
    wr_reg(dbc_pkg::GLOBAL_CH, dbc_pkg::REG_CONTROL, 32'h0);
    chk_reg(4'h0, dbc_pkg::REG_COUNT_COR, b0 + 32'h3);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, b0 + 32'h3);
    repeat (300) @(posedge clk);
    chk_reg(4'h0, dbc_pkg::REG_COUNT, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
